//--- design/tmc_defs.svh
// Constants of the 16-bit timer/counter core: offsets, fields, reset values.
// Assumes a 32-bit AXI4-Lite register bus and one 200 MHz clock.
//
// Summary of operation
// (R1) Start code 01 starts on command; 11 uses falling edges or a low window.
// (R2) Start code 00 halts and clears the counter; 10 is 11 with rising edges.
// (R3) Clock codes 00/01/10 divide by 2^11/2^7/2^3, or 2^12/2^8/2^4 with divider set.
// (R4) Clock code 11 advances the counter on edges of the input pin.
// (R5) Mode 00 is timer/trigger/event, 01 is window, 11 is pulse generation.
// (R6) A compare register takes its new value at the first source tick after upper byte.
// (R7) A lower-byte write alone leaves the active compare value unchanged.
// (R8) Software changes mode, clock, continuity and flip-flop only while start is 00.
// (R9) Auto-capture works only in plain timer, event counter and window modes.
// (R10) Software keeps A above B above 1 in pulse mode, else A above 1.
// (R11) Software keeps the output flip-flop bit at 0 outside pulse mode.
// (R12) Software writes register B only after selecting pulse generation mode.
// (R13) Stop-state entry forces start code to 00 and halts counting.
// (R14) Software reads captured counts only while capture is on and counter runs.
// (R15) Auto-capture copies the counter into B on source ticks; first read waits one.
// (R16) Timer mode increments the counter on every selected source tick once started.
// (R17) Counter equal to A raises the interrupt request, clears, and counts on; the code stops instead in edge-triggered timer mode and one-shot pulse mode.
// (R18) Auto-capture enable set to 1 keeps copying the running count into B.
// (R19) B accepts writes only in pulse mode; both data registers reset to all ones.
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH

`define TMC_OFS_CONTROL     8'h00
`define TMC_OFS_CMP_A       8'h04
`define TMC_OFS_CMP_B       8'h08
`define TMC_OFS_GEAR        8'h0C
`define TMC_OFS_STATUS      8'h10
`define TMC_OFS_ENABLE      8'h14
`define TMC_OFS_CLEAR       8'h18

`define TMC_CTL_MODE_LSB    0
`define TMC_CTL_CLK_LSB     2
`define TMC_CTL_START_LSB   4
`define TMC_CTL_OPT_BIT     6
`define TMC_CTL_TFF_BIT     7
`define TMC_CTL_RESET       8'h00
`define TMC_DATA_RESET      16'hFFFF

`define TMC_IRQ_MATCH_BIT   0
`define TMC_IRQ_PULSE_BIT   1

`define TMC_RESP_OKAY       2'h0
`define TMC_RESP_SLVERR     2'h2

`endif

//--- design/tmc_pkg.sv
// Types of the 16-bit timer/counter core.
// Assumes the constants header is included by each module that needs numbers.
package tmc_pkg;

   typedef enum logic [1:0] {
      TMC_START_STOP = 2'b00,
      TMC_START_CMD  = 2'b01,
      TMC_START_RISE = 2'b10,
      TMC_START_FALL = 2'b11
   } tmc_start_t;

   typedef enum logic [1:0] {
      TMC_MODE_TIMER  = 2'b00,
      TMC_MODE_WINDOW = 2'b01,
      TMC_MODE_RSVD   = 2'b10,
      TMC_MODE_PULSE  = 2'b11
   } tmc_mode_t;

   typedef enum logic {
      TMC_IDLE = 1'b0,
      TMC_RUN  = 1'b1
   } tmc_run_t;

endpackage

//--- design/tmc_prescaler.sv
// Free-running divider of the system clock with a selectable tap.
// Assumes a synchronous active-low reset; tick is one cycle per tap period.
`timescale 1ns/1ps
module tmc_prescaler
#(
   parameter int DIV_W = 12
)
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [1:0] tap_select,
   input  wire logic       divider_select,
   output logic            tick
);
   logic [DIV_W-1:0] div;
   logic [DIV_W-1:0] tap_mask;

   // Low bits all ones mark one tick per 2^k cycles, see (R3)
   assign tap_mask = (tap_select == 2'b00) ? (divider_select ? 12'hFFF : 12'h7FF) :
                     (tap_select == 2'b01) ? (divider_select ? 12'h0FF : 12'h07F) :
                                             (divider_select ? 12'h00F : 12'h007);

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         div  <= '0;
         tick <= 1'b0;
      end
      else
      begin
         div  <= div + 1'b1;
         tick <= ((div & tap_mask) == tap_mask);
      end
   end
endmodule

//--- design/tmc_edge_detect.sv
// Edge detector for the timer input pin.
// Assumes the pin is already synchronous to clk.
`timescale 1ns/1ps
module tmc_edge_detect
(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic pin,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         level <= 1'b0;
         rise  <= 1'b0;
         fall  <= 1'b0;
      end
      else
      begin
         level <= pin;
         rise  <= pin & ~level;
         fall  <= ~pin & level;
      end
   end
endmodule

//--- design/tmc_timer_top.sv
// Control and counting core of the 16-bit timer/counter with AXI4-Lite slave.
// Assumes one clock, synchronous active-low reset, pin synchronous to clk.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "tmc_defs.svh"
module tmc_timer_top
   import tmc_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              timer_input_pin,
   input  wire logic              stop_mode_entry,
   output logic                   timer_interrupt_request,
   output logic                   pulse_out
);
   // Register state
   logic [7:0]        timer_control;
   logic              divider_select;
   logic [15:0]       compare_register_a;
   logic [15:0]       compare_capture_register_b;
   logic [7:0]        compare_a_lower_byte;
   logic [7:0]        compare_a_upper_byte;
   logic [7:0]        compare_b_lower_byte;
   logic [7:0]        compare_b_upper_byte;
   logic              a_pending;
   logic              b_pending;
   logic [1:0]        irq_status;
   logic [1:0]        irq_enable;
   logic [15:0]       count;
   tmc_run_t          run_state;
   tmc_run_t          next_run_state;

   // Bus state
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0]       wr_data;
   logic [3:0]        wr_strb;
   logic              aw_have;
   logic              w_have;

   // Fields and decode
   tmc_start_t        start_control;
   tmc_mode_t         operating_mode_select;
   logic [1:0]        source_clock_select;
   logic              option_bit;
   logic              output_flipflop_control;
   logic              ext_clock;
   logic              pre_tick;
   logic              pin_level;
   logic              pin_rise;
   logic              pin_fall;
   logic              sel_edge;
   logic              src_tick;
   logic              window_open;
   logic              trigger_type;
   logic              count_en;
   logic [15:0]       count_inc;
   logic              match_a;
   logic              match_b;
   logic              capture_ok;
   logic              one_shot;
   logic              wr_fire;
   logic              wr_ctl;
   logic              wr_a;
   logic              wr_b;
   logic              wr_gear;
   logic              wr_en;
   logic              wr_clr;
   logic              wr_ro;
   logic              wr_hit;
   logic [1:0]        irq_set;
   logic [1:0]        irq_clr;
   logic [1:0]        next_irq_status;
   logic [7:0]        next_timer_control;
   logic              rd_hit;
   logic [31:0]       rd_mux;

   assign start_control           = tmc_start_t'(timer_control[`TMC_CTL_START_LSB +: 2]);
   assign operating_mode_select   = tmc_mode_t'(timer_control[`TMC_CTL_MODE_LSB +: 2]);
   assign source_clock_select     = timer_control[`TMC_CTL_CLK_LSB +: 2];
   assign option_bit              = timer_control[`TMC_CTL_OPT_BIT];
   assign output_flipflop_control = timer_control[`TMC_CTL_TFF_BIT];

   tmc_prescaler #(
      .DIV_W          (12)
   ) i_tmc_prescaler (
      .clk            (clk),
      .resetn         (resetn),
      .tap_select     (source_clock_select),
      .divider_select (divider_select),
      .tick           (pre_tick)
   );

   tmc_edge_detect i_tmc_edge_detect (
      .clk    (clk),
      .resetn (resetn),
      .pin    (timer_input_pin),
      .level  (pin_level),
      .rise   (pin_rise),
      .fall   (pin_fall)
   );

   // Edge polarity from start code: 11 falling, otherwise rising, see (R1) (R2)
   assign sel_edge     = (start_control == TMC_START_RISE) ? pin_rise :
                         (start_control == TMC_START_FALL) ? pin_fall : pin_rise;
   assign ext_clock    = (source_clock_select == 2'b11);
   // Pin edges replace the prescaler tap, see (R4)
   assign src_tick     = ext_clock ? sel_edge : pre_tick;
   // Window logic: 10 counts while high, 11 while low, see (R1) (R2)
   assign window_open  = (start_control == TMC_START_RISE) ? pin_level : ~pin_level;
   // Mode group select, see (R5)
   assign trigger_type = start_control[1] & ~ext_clock &
                         ((operating_mode_select == TMC_MODE_TIMER) |
                          (operating_mode_select == TMC_MODE_PULSE));
   assign count_en     = (run_state == TMC_RUN) & (start_control != TMC_START_STOP) & src_tick &
                         ((operating_mode_select != TMC_MODE_WINDOW) | window_open);
   assign count_inc    = count + 16'h0001;
   assign match_a      = count_en & (count_inc == compare_register_a);
   assign match_b      = count_en & (operating_mode_select == TMC_MODE_PULSE) &
                         (count_inc == compare_capture_register_b);
   assign one_shot     = (operating_mode_select == TMC_MODE_PULSE) & option_bit;
   // Capture only in plain timer, event counter and window modes, see (R9)
   assign capture_ok   = option_bit & (run_state == TMC_RUN) &
                         (((operating_mode_select == TMC_MODE_TIMER) &
                           ((start_control == TMC_START_CMD) | ext_clock)) |
                          (operating_mode_select == TMC_MODE_WINDOW));

   // Run state
   always_comb
   begin
      next_run_state = run_state;
      case (run_state)
         TMC_IDLE:
         begin
            if (start_control == TMC_START_CMD)
               next_run_state = TMC_RUN;
            else if (start_control[1] & ~trigger_type)
               next_run_state = TMC_RUN;
            else if (trigger_type & sel_edge)
               next_run_state = TMC_RUN;
         end
         TMC_RUN:
         begin
            if (start_control == TMC_START_STOP)
               next_run_state = TMC_IDLE;
            else if (match_a & (one_shot |
                     (trigger_type & (operating_mode_select == TMC_MODE_TIMER))))
               next_run_state = TMC_IDLE;
         end
         default:
            next_run_state = TMC_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         run_state <= TMC_IDLE;
      else
         run_state <= next_run_state;
   end

   // Up-counter: clear on stop, clear on compare match, else count, see (R2) (R16) (R17)
   always_ff @(posedge clk)
   begin
      if (!resetn)
         count <= 16'h0000;
      else if (start_control == TMC_START_STOP)
         count <= 16'h0000;
      else if (match_a)
         count <= 16'h0000;
      else if (count_en)
         count <= count_inc;
   end

   // Pulse output toggles at B and A matches, rests at the flip-flop bit
   always_ff @(posedge clk)
   begin
      if (!resetn)
         pulse_out <= 1'b0;
      else if ((run_state == TMC_IDLE) | (start_control == TMC_START_STOP))
         pulse_out <= output_flipflop_control;
      else if (match_a ^ match_b)
         pulse_out <= ~pulse_out;
   end

   // Bus write decode
   assign wr_fire = aw_have & w_have & ~s_axi_bvalid;
   assign wr_ctl  = wr_fire & (wr_addr == `TMC_OFS_CONTROL);
   assign wr_a    = wr_fire & (wr_addr == `TMC_OFS_CMP_A);
   assign wr_b    = wr_fire & (wr_addr == `TMC_OFS_CMP_B);
   assign wr_gear = wr_fire & (wr_addr == `TMC_OFS_GEAR);
   assign wr_en   = wr_fire & (wr_addr == `TMC_OFS_ENABLE);
   assign wr_clr  = wr_fire & (wr_addr == `TMC_OFS_CLEAR);
   assign wr_ro   = (wr_addr == `TMC_OFS_STATUS);
   assign wr_hit  = wr_ctl | wr_a | wr_b | wr_gear | wr_en | wr_clr | (wr_fire & wr_ro);

   // Stop-state entry wins over a software write of the start field, see (R13)
   assign next_timer_control = (wr_ctl & wr_strb[0]) ? wr_data[7:0] : timer_control;

   always_ff @(posedge clk)
   begin
      if (!resetn)
         timer_control <= `TMC_CTL_RESET;
      else if (stop_mode_entry)
         timer_control <= {next_timer_control[7:6], 2'b00, next_timer_control[3:0]};
      else
         timer_control <= next_timer_control;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         divider_select <= 1'b0;
      else if (wr_gear & wr_strb[0])
         divider_select <= wr_data[0];
   end

   // Byte staging of compare A; upper byte arms the load, see (R6) (R7)
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         compare_a_lower_byte <= 8'hFF;
         compare_a_upper_byte <= 8'hFF;
         a_pending            <= 1'b0;
         compare_register_a   <= `TMC_DATA_RESET;
      end
      else
      begin
         if (wr_a & wr_strb[0])
            compare_a_lower_byte <= wr_data[7:0];
         if (wr_a & wr_strb[1])
            compare_a_upper_byte <= wr_data[15:8];
         if (wr_a & wr_strb[1])
            a_pending <= 1'b1;
         else if (src_tick)
            a_pending <= 1'b0;
         if (a_pending & src_tick)
            compare_register_a <= {compare_a_upper_byte, compare_a_lower_byte};
      end
   end

   // Compare B: writes only in pulse mode, loads on tick; capture copies count,
   // see (R6) (R7) (R15) (R18) (R19)
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         compare_b_lower_byte       <= 8'hFF;
         compare_b_upper_byte       <= 8'hFF;
         b_pending                  <= 1'b0;
         compare_capture_register_b <= `TMC_DATA_RESET;
      end
      else
      begin
         if (wr_b & wr_strb[0] & (operating_mode_select == TMC_MODE_PULSE))
            compare_b_lower_byte <= wr_data[7:0];
         if (wr_b & wr_strb[1] & (operating_mode_select == TMC_MODE_PULSE))
            compare_b_upper_byte <= wr_data[15:8];
         if (wr_b & wr_strb[1] & (operating_mode_select == TMC_MODE_PULSE))
            b_pending <= 1'b1;
         else if (src_tick)
            b_pending <= 1'b0;
         if (capture_ok & src_tick)
            compare_capture_register_b <= count;
         else if (b_pending & src_tick)
            compare_capture_register_b <= {compare_b_upper_byte, compare_b_lower_byte};
      end
   end

   // Interrupt status: set wins over clear, see (R17)
   assign irq_set         = {match_b, match_a};
   assign irq_clr         = (wr_clr & wr_strb[0]) ? wr_data[1:0] : 2'b00;
   assign next_irq_status = (irq_status & ~irq_clr) | irq_set;

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         irq_status              <= 2'b00;
         irq_enable              <= 2'b00;
         timer_interrupt_request <= 1'b0;
      end
      else
      begin
         irq_status <= next_irq_status;
         if (wr_en & wr_strb[0])
            irq_enable <= wr_data[1:0];
         timer_interrupt_request <= |(irq_status & irq_enable);
      end
   end

   // Write channels
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         aw_have       <= 1'b0;
         w_have        <= 1'b0;
         wr_addr       <= '0;
         wr_data       <= 32'h00000000;
         wr_strb       <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `TMC_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_have       <= 1'b1;
            wr_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_have       <= 1'b1;
            wr_data      <= s_axi_wdata;
            wr_strb      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
         end
         if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Read decode
   assign rd_hit = (s_axi_araddr == `TMC_OFS_CONTROL) | (s_axi_araddr == `TMC_OFS_CMP_A) |
                   (s_axi_araddr == `TMC_OFS_CMP_B) | (s_axi_araddr == `TMC_OFS_GEAR) |
                   (s_axi_araddr == `TMC_OFS_STATUS) | (s_axi_araddr == `TMC_OFS_ENABLE) |
                   (s_axi_araddr == `TMC_OFS_CLEAR);
   assign rd_mux =
      (s_axi_araddr == `TMC_OFS_CONTROL) ? {24'h000000, timer_control} :
      (s_axi_araddr == `TMC_OFS_CMP_A)   ? {16'h0000, compare_register_a} :
      (s_axi_araddr == `TMC_OFS_CMP_B)   ? {16'h0000, compare_capture_register_b} :
      (s_axi_araddr == `TMC_OFS_GEAR)    ? {31'h00000000, divider_select} :
      (s_axi_araddr == `TMC_OFS_STATUS)  ? {30'h00000000, irq_status} :
      (s_axi_araddr == `TMC_OFS_ENABLE)  ? {30'h00000000, irq_enable} :
                                           32'h00000000;

   // Read channel
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `TMC_RESP_OKAY;
      end
      else if (s_axi_arvalid & s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_mux;
         s_axi_rresp   <= rd_hit ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end
endmodule

//--- verification/tmc_timer_top_sva.sv
// Checker of the timer core: bus handshakes, reset state, interrupt output.
// Sees only the ports of tmc_timer_top; bound to it below.
`timescale 1ns/1ps
module tmc_timer_top_sva
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        stop_mode_entry,
   input wire logic        timer_interrupt_request
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   property p_bdone;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
   endproperty
   a_bdone: assert property (p_bdone) else $error("write channels not freed");
   property p_bboth;
      $rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_bboth: assert property (p_bboth) else $error("write answer before both taken");
   property p_rans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rans: assert property (p_rans) else $error("read answer late");
   property p_rcause;
      $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready);
   endproperty
   a_rcause: assert property (p_rcause) else $error("read answer without request");
   property p_rdone;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##0 s_axi_arready;
   endproperty
   a_rdone: assert property (p_rdone) else $error("read channel not freed");
   property p_rst;
      $rose(resetn) |-> s_axi_awready && s_axi_arready && !s_axi_bvalid
         && !s_axi_rvalid && !timer_interrupt_request;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not idle after reset");
   property p_stop;
      (stop_mode_entry && !s_axi_bvalid) [*4] |-> !$rose(timer_interrupt_request);
   endproperty
   a_stop: assert property (p_stop) else $error("interrupt while stopped");
   property p_irqhold;
      timer_interrupt_request && !s_axi_bvalid |=> timer_interrupt_request;
   endproperty
   a_irqhold: assert property (p_irqhold) else $error("interrupt lost");

   c_irq: cover property ($rose(timer_interrupt_request));
   c_stop: cover property (stop_mode_entry [*4]);
   c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind tmc_timer_top tmc_timer_top_sva i_tmc_timer_top_sva
(
   .clk                     (clk),
   .resetn                  (resetn),
   .s_axi_awready           (s_axi_awready),
   .s_axi_wready            (s_axi_wready),
   .s_axi_bvalid            (s_axi_bvalid),
   .s_axi_bready            (s_axi_bready),
   .s_axi_arvalid           (s_axi_arvalid),
   .s_axi_arready           (s_axi_arready),
   .s_axi_rvalid            (s_axi_rvalid),
   .s_axi_rready            (s_axi_rready),
   .stop_mode_entry         (stop_mode_entry),
   .timer_interrupt_request (timer_interrupt_request)
);

//--- verification/tmc_timer_top_test.sv
// Bench of the timer core: register map, periods, pin counting, stop, capture.
// Drives the AXI4-Lite slave and the timer pin itself; one 200 MHz clock.
`timescale 1ns/1ps
`include "tmc_defs.svh"
module tmc_timer_top_test;
   logic        clk = 1'h0;
   logic        resetn = 1'h0;
   logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic        pin = 1'h0, stop = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid, irq, pout;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rdata, rdv;
   logic [31:0] rst_v [7] = '{32'h0, 32'hFFFF, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0};
   int          bad_count = 0;
   int          checks = 0;
   int          cyc = 0;
   int          seed = 39;

   tmc_timer_top #(.ADDR_W(8)) i_tmc_timer_top
   (
      .clk                     (clk),
      .resetn                  (resetn),
      .s_axi_awaddr            (awaddr),
      .s_axi_awprot            (3'h0),
      .s_axi_awvalid           (awvalid),
      .s_axi_awready           (awready),
      .s_axi_wdata             (wdata),
      .s_axi_wstrb             (wstrb),
      .s_axi_wvalid            (wvalid),
      .s_axi_wready            (wready),
      .s_axi_bresp             (bresp),
      .s_axi_bvalid            (bvalid),
      .s_axi_bready            (bready),
      .s_axi_araddr            (araddr),
      .s_axi_arprot            (3'h0),
      .s_axi_arvalid           (arvalid),
      .s_axi_arready           (arready),
      .s_axi_rdata             (rdata),
      .s_axi_rresp             (rresp),
      .s_axi_rvalid            (rvalid),
      .s_axi_rready            (rready),
      .timer_input_pin         (pin),
      .stop_mode_entry         (stop),
      .timer_interrupt_request (irq),
      .pulse_out               (pout)
   );

   always #2.5 clk = ~clk;

   task automatic stop_test;
      if (bad_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 80000)
      begin
         bad_count++;
         stop_test;
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      do
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
      end
      while (!bvalid);
      bready <= 1'h0;
      resp = bresp;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      do
      begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'h0;
      end
      while (!rvalid);
      rready <= 1'h0;
      rdv = rdata;
      resp = rresp;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk($sformatf("reg %h", a), e, rdv);
   endtask

   function automatic int sh(input logic [1:0] c, input logic d);
      return d + (c == 2'h0 ? 11 : c == 2'h1 ? 7 : 3);
   endfunction

   // Control with start 00, divider, compare A, load tick, then a lone lower byte
   task automatic setup(input logic [7:0] c, input logic d, input logic [15:0] a);
      wr(`TMC_OFS_CONTROL, {24'h0, c});
      wr(`TMC_OFS_GEAR, {31'h0, d});
      wr(`TMC_OFS_CMP_A, {16'h0, a});
      repeat ((1 << sh(c[3:2], d)) + 4) @(posedge clk);
      wr(`TMC_OFS_CMP_A, 32'hFF, 4'h1);
   endtask

   task automatic wait_irq;
      do
         @(posedge clk);
      while (!irq);
   endtask

   initial
   begin
      logic [31:0] b1;
      int          t1;
      int          a;
      repeat (10) @(posedge clk);
      resetn <= 1'h1;
      for (int i = 0; i < 7; i++)
         rc(8'(4 * i), rst_v[i]);
      rd(8'h1C);
      chk("rresp", `TMC_RESP_SLVERR, resp);
      wr(8'h1C, 32'h1);
      chk("bresp", `TMC_RESP_SLVERR, resp);
      wr(`TMC_OFS_CMP_B, $random(seed) & 32'hFFFF);
      repeat (20) @(posedge clk);
      rc(`TMC_OFS_CMP_B, 32'hFFFF);
      for (int i = 0; i < 6; i++)
      begin
         a = 2 + ($random(seed) & 1);
         setup(8'((i % 3) << 2), i / 3, 16'(a));
         wr(`TMC_OFS_ENABLE, 32'h1);
         wr(`TMC_OFS_CONTROL, 32'h10 | ((i % 3) << 2));
         wait_irq;
         t1 = cyc;
         wr(`TMC_OFS_CLEAR, 32'h1);
         wait_irq;
         chk("period", a << sh(2'(i % 3), i / 3), cyc - t1);
         wr(`TMC_OFS_CONTROL, (i % 3) << 2);
         wr(`TMC_OFS_CLEAR, 32'h1);
         wr(`TMC_OFS_ENABLE, 32'h0);
      end
      for (int st = 2; st < 4; st++)
      begin
         setup(8'h08, 1'h0, 16'h3);
         wr(`TMC_OFS_CONTROL, 32'h0C);
         pin <= (st == 3);
         wr(`TMC_OFS_CONTROL, 32'h0C | (st << 4));
         for (int k = 1; k < 4; k++)
         begin
            pin <= (st == 2);
            repeat (4) @(posedge clk);
            pin <= (st == 3);
            repeat (4) @(posedge clk);
            if (k == 2)
               rc(`TMC_OFS_STATUS, 32'h0);
         end
         rc(`TMC_OFS_STATUS, 32'h1);
         chk("irq masked", 32'h0, irq);
         wr(`TMC_OFS_ENABLE, 32'h1);
         @(posedge clk);
         chk("irq", 32'h1, irq);
         wr(`TMC_OFS_CLEAR, 32'h1);
         wr(`TMC_OFS_ENABLE, 32'h0);
         wr(`TMC_OFS_CONTROL, 32'h0C);
      end
      setup(8'h08, 1'h0, 16'h3);
      wr(`TMC_OFS_CONTROL, 32'h18);
      repeat (30) @(posedge clk);
      stop <= 1'h1;
      repeat (4) @(posedge clk);
      stop <= 1'h0;
      rc(`TMC_OFS_CONTROL, 32'h08);
      wr(`TMC_OFS_CLEAR, 32'h1);
      repeat (40) @(posedge clk);
      rc(`TMC_OFS_STATUS, 32'h0);
      setup(8'h09, 1'h0, 16'h40);
      wr(`TMC_OFS_CONTROL, 32'h69);
      repeat (16) @(posedge clk);
      rd(`TMC_OFS_CMP_B);
      b1 = rdv;
      chk("capture range", 32'h1, b1 < 32'h40);
      repeat (24) @(posedge clk);
      rd(`TMC_OFS_CMP_B);
      chk("capture moves", 32'h1, rdv != b1);
      wr(`TMC_OFS_CONTROL, 32'h09);
      wr(`TMC_OFS_CONTROL, 32'h0B);
      wr(`TMC_OFS_CMP_B, 32'h2);
      repeat (12) @(posedge clk);
      wr(`TMC_OFS_CONTROL, 32'h5B);
      repeat (40) @(posedge clk);
      rc(`TMC_OFS_CMP_B, 32'h2);
      wr(`TMC_OFS_CONTROL, 32'h0B);
      wr(`TMC_OFS_CONTROL, 32'h8B);
      @(posedge clk);
      chk("pulse rest", 32'h1, pout);
      wr(`TMC_OFS_CONTROL, 32'h0B);
      wr(`TMC_OFS_CONTROL, 32'h08);
      stop_test;
   end
endmodule
